/* common/ctmc_regs.svh */
// Constants for the CAN transceiver mode controller: register map,
// field positions, the identification value and timing figures.
// Assumes a 100 MHz core clock and a 32-bit APB register port.
`ifndef CTMC_REGS_SVH
`define CTMC_REGS_SVH

// ==========================================================================
// Register map (byte addresses)
`define CTMC_ADDR_W 12
`define CTMC_STATUS_ADDR 12'h000
`define CTMC_CTRL_ADDR 12'h004
`define CTMC_ID_ADDR 12'h008

// ==========================================================================
// Status fields
`define CTMC_ST_MODE_LSB 0
`define CTMC_ST_MODE_MSB 2
`define CTMC_ST_WAKE_BIT 3
`define CTMC_ST_PWRUP_BIT 4
`define CTMC_ST_LWAKE_BIT 5
`define CTMC_ST_INH_BIT 6
`define CTMC_ST_SUPPLY_LSB 7
`define CTMC_ST_SUPPLY_MSB 9

// ==========================================================================
// Control fields (write one to clear)
`define CTMC_CT_CLR_WAKE_BIT 0
`define CTMC_CT_CLR_PWRUP_BIT 1

// Identification value is arbitrary.
`define CTMC_ID_VALUE 32'h0000_c7c1

// ==========================================================================
// Timing
`define CTMC_CLK_PERIOD_NS 10
`define CTMC_SLEEP_HOLD_NS 50000
`define CTMC_BUS_WAKE_NS 1000
`define CTMC_LOCAL_WAKE_NS 10000
`define CTMC_CNT_W 16

`endif

/* common/ctmc_pkg.sv */
// Types shared by the CAN transceiver mode controller.
// Assumes nothing beyond a SystemVerilog compiler.
package ctmc_pkg;

  // ========================================================================
  // Operating modes
  typedef enum logic [2:0] {
    MODE_NORMAL,
    MODE_RXONLY,
    MODE_STANDBY,
    MODE_GOTOSLEEP,
    MODE_SLEEP
  } ctmc_mode_e;

  typedef logic [15:0] ctmc_count_t;

endpackage : ctmc_pkg

/* src/ctmc_top.sv */
// Mode controller of a high-speed CAN transceiver with wake detection.
// Assumes all pins are synchronous to core_clk, supply monitors arrive as
// active-high "present" levels, and reset marks the power-up moment.
`include "ctmc_regs.svh"

module ctmc_top #(
  parameter int unsigned SLEEP_HOLD_CYC =
    `CTMC_SLEEP_HOLD_NS / `CTMC_CLK_PERIOD_NS
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic normal_select,
  input wire logic standby_n_select,
  input wire logic transmit_input,
  input wire logic bus_dominant,
  input wire logic local_wake_in,
  input wire logic vs_ok,
  input wire logic vcc_ok,
  input wire logic vio_ok,
  input wire logic failure_detected,
  input wire logic supply_switch_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CTMC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic bus_drive_dominant,
  output logic receive_output,
  output logic error_flag_n,
  output logic supply_switch_out,
  output logic supply_switch_oe_n
);

  // ========================================================================
  // Timing counts
  localparam int unsigned BUS_WAKE_CYC =
    `CTMC_BUS_WAKE_NS / `CTMC_CLK_PERIOD_NS;
  localparam int unsigned LOCAL_WAKE_CYC =
    `CTMC_LOCAL_WAKE_NS / `CTMC_CLK_PERIOD_NS;
  localparam ctmc_pkg::ctmc_count_t HOLD_LAST =
    ctmc_pkg::ctmc_count_t'(SLEEP_HOLD_CYC - 1);
  localparam ctmc_pkg::ctmc_count_t BUS_LAST =
    ctmc_pkg::ctmc_count_t'(BUS_WAKE_CYC - 1);
  localparam ctmc_pkg::ctmc_count_t LOCAL_LAST =
    ctmc_pkg::ctmc_count_t'(LOCAL_WAKE_CYC - 1);
  localparam ctmc_pkg::ctmc_count_t CNT_ONE = 16'h0001;

  function automatic logic low_power_mode(input ctmc_pkg::ctmc_mode_e m);
    low_power_mode = (m == ctmc_pkg::MODE_STANDBY) ||
                     (m == ctmc_pkg::MODE_GOTOSLEEP) ||
                     (m == ctmc_pkg::MODE_SLEEP);
  endfunction : low_power_mode

  function automatic logic active_mode(input ctmc_pkg::ctmc_mode_e m);
    active_mode = (m == ctmc_pkg::MODE_NORMAL) ||
                  (m == ctmc_pkg::MODE_RXONLY);
  endfunction : active_mode

  // ========================================================================
  // State
  ctmc_pkg::ctmc_mode_e mode;
  ctmc_pkg::ctmc_mode_e next_mode;
  ctmc_pkg::ctmc_count_t hold_cnt;
  ctmc_pkg::ctmc_count_t bus_cnt;
  ctmc_pkg::ctmc_count_t lw_cnt;
  logic [1:0] pins_prev;
  logic pins_valid;
  logic supplies_prev;
  logic bus_armed;
  logic lw_level;
  logic wake_flag;
  logic pwrup_flag;
  logic lwake_src;

  // ========================================================================
  // Event decode
  wire logic [1:0] pins = {normal_select, standby_n_select};
  wire logic all_ok = vs_ok && vcc_ok && vio_ok;
  wire logic logic_ok = vcc_ok && vio_ok;
  wire logic pin_event = pins_valid && (pins != pins_prev) && all_ok;
  wire logic logic_uv = supplies_prev && !logic_ok;
  wire logic in_gts = (mode == ctmc_pkg::MODE_GOTOSLEEP);
  wire logic hold_done = in_gts && (hold_cnt >= HOLD_LAST);
  wire logic lp_on = low_power_mode(mode);
  // A steady dominant bus never arms the filter, so it cannot wake.
  wire logic bus_wake = lp_on && bus_armed && bus_dominant &&
                        (bus_cnt >= BUS_LAST);
  wire logic lw_differs = (local_wake_in != lw_level);
  wire logic local_wake = lp_on && lw_differs &&
                          (lw_cnt >= LOCAL_LAST);
  wire logic any_wake = bus_wake || local_wake;

  // Bus level enters the mode decisions below only through the filtered bus wake out of Sleep.
  always_comb begin
    next_mode = mode;
    if (!vs_ok) begin
      next_mode = ctmc_pkg::MODE_STANDBY;
    end else if (logic_uv) begin
      next_mode = ctmc_pkg::MODE_SLEEP;
    end else if (mode == ctmc_pkg::MODE_SLEEP && any_wake) begin
      next_mode = ctmc_pkg::MODE_STANDBY;
    end else if (pin_event) begin
      case (pins)
        2'h3: next_mode = ctmc_pkg::MODE_NORMAL;
        2'h1: next_mode = ctmc_pkg::MODE_RXONLY;
        2'h2: begin
          if (mode != ctmc_pkg::MODE_SLEEP) begin
            next_mode = ctmc_pkg::MODE_GOTOSLEEP;
          end
        end
        2'h0: begin
          // The controller drops standby first; a normal-pin fall
          // inside the hold window lands in Stand-By.
          if (active_mode(mode) || in_gts) begin
            next_mode = ctmc_pkg::MODE_STANDBY;
          end
        end
        default: next_mode = mode;
      endcase
    end else if (hold_done) begin
      next_mode = ctmc_pkg::MODE_SLEEP;
    end
  end

  // ========================================================================
  // Mode register and Go-To-Sleep timer
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      mode <= ctmc_pkg::MODE_STANDBY;
    end else begin
      mode <= next_mode;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !in_gts) begin
      hold_cnt <= 16'h0000;
    end else if (!hold_done) begin
      hold_cnt <= hold_cnt + CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pins_prev <= 2'h0;
      pins_valid <= 1'b0;
      supplies_prev <= 1'b0;
    end else begin
      pins_prev <= pins;
      pins_valid <= 1'b1;
      supplies_prev <= logic_ok;
    end
  end

  // ========================================================================
  // Wake filters
  always_ff @(posedge core_clk) begin
    if (!rst_b || !lp_on) begin
      bus_armed <= 1'b0;
      bus_cnt <= 16'h0000;
    end else begin
      if (!bus_dominant) begin
        bus_armed <= 1'b1;
        bus_cnt <= 16'h0000;
      end else if (bus_wake) begin
        bus_armed <= 1'b0;
        bus_cnt <= 16'h0000;
      end else if (bus_armed) begin
        bus_cnt <= bus_cnt + CNT_ONE;
      end
    end
  end

  // The filtered level follows the pin while disabled, so that enabling
  // the input never fires on an old change.
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lw_level <= 1'b0;
      lw_cnt <= 16'h0000;
    end else if (!lp_on) begin
      lw_level <= local_wake_in;
      lw_cnt <= 16'h0000;
    end else if (!lw_differs) begin
      lw_cnt <= 16'h0000;
    end else if (local_wake) begin
      lw_level <= local_wake_in;
      lw_cnt <= 16'h0000;
    end else begin
      lw_cnt <= lw_cnt + CNT_ONE;
    end
  end

  // ========================================================================
  // Flags: a hardware set wins over a software clear
  wire logic ctrl_wr = psel && penable && pwrite && pready &&
                       (paddr == `CTMC_CTRL_ADDR);
  wire logic clr_wake = ctrl_wr && pwdata[`CTMC_CT_CLR_WAKE_BIT];
  wire logic clr_pwrup = ctrl_wr && pwdata[`CTMC_CT_CLR_PWRUP_BIT];

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      wake_flag <= 1'b0;
      lwake_src <= 1'b0;
      pwrup_flag <= 1'b1;
    end else begin
      if (!vs_ok) begin
        wake_flag <= 1'b0;
      end else if (any_wake) begin
        wake_flag <= 1'b1;
        lwake_src <= local_wake;
      end else if (clr_wake) begin
        wake_flag <= 1'b0;
      end
      if (!vs_ok) begin
        pwrup_flag <= 1'b1;
      end else if (clr_pwrup) begin
        pwrup_flag <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Pin outputs
  wire logic next_drive = (next_mode == ctmc_pkg::MODE_NORMAL) &&
                          !transmit_input;
  wire logic sb_next = (next_mode == ctmc_pkg::MODE_STANDBY);
  wire logic sleep_next = (next_mode == ctmc_pkg::MODE_SLEEP);
  wire logic wake_show = (sb_next || sleep_next) && logic_ok &&
                         wake_flag;
  wire logic next_rx = active_mode(next_mode) ? !bus_dominant :
                       !wake_show;
  wire logic next_err_n = active_mode(next_mode) ? !failure_detected :
                          !(sb_next && logic_ok &&
                            (wake_flag || pwrup_flag));

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      bus_drive_dominant <= 1'b0;
      receive_output <= 1'b1;
      error_flag_n <= 1'b1;
      supply_switch_out <= 1'b1;
      supply_switch_oe_n <= 1'b0;
    end else begin
      bus_drive_dominant <= next_drive;
      receive_output <= next_rx;
      error_flag_n <= next_err_n;
      supply_switch_out <= 1'b1;
      supply_switch_oe_n <= sleep_next;
    end
  end

  // ========================================================================
  // APB slave: no wait state, answer in the first access cycle
  wire logic setup = psel && !penable;
  wire logic hit_status = (paddr == `CTMC_STATUS_ADDR);
  wire logic hit_ctrl = (paddr == `CTMC_CTRL_ADDR);
  wire logic hit_id = (paddr == `CTMC_ID_ADDR);
  wire logic mapped = hit_status || hit_ctrl || hit_id;
  wire logic [31:0] status_word = {22'h000000,
                                   vio_ok, vcc_ok, vs_ok,
                                   supply_switch_in, lwake_src,
                                   pwrup_flag, wake_flag, mode};
  wire logic [31:0] next_rdata = pwrite ? 32'h0000_0000 :
                                 hit_status ? status_word :
                                 hit_id ? `CTMC_ID_VALUE : 32'h0000_0000;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup) begin
        prdata <= next_rdata;
      end
    end
  end

  // ========================================================================
  // Checks
  // Two checks, gts_bound_a and stuck_bus_a, keep their own view of time, apart
  // from the counters that the logic above relies on; gts_entry_a, gts_start_a and hold_limit_a read hold_cnt.
  ctmc_pkg::ctmc_count_t gts_age;
  ctmc_pkg::ctmc_count_t dom_run;
  logic rec_seen;

  always_ff @(posedge core_clk) begin
    if (!rst_b || !in_gts) begin
      gts_age <= 16'h0000;
    end else begin
      gts_age <= gts_age + CNT_ONE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !lp_on) begin
      dom_run <= 16'h0000;
      rec_seen <= 1'b0;
    end else if (!bus_dominant) begin
      dom_run <= 16'h0000;
      rec_seen <= 1'b1;
    end else if (dom_run < BUS_LAST) begin
      dom_run <= dom_run + CNT_ONE;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_gts_enter;
    mode == ctmc_pkg::MODE_GOTOSLEEP && $past(mode) != mode;
  endsequence

  normal_entry_a: assert property (
    pin_event && pins == 2'h3 && !logic_uv |=> mode == ctmc_pkg::MODE_NORMAL)
    else $error("normal mode not entered");
  rxonly_entry_a: assert property (
    pin_event && pins == 2'h1 && !logic_uv |=> mode == ctmc_pkg::MODE_RXONLY)
    else $error("receive-only mode not entered");
  gts_entry_a: assert property (
    pin_event && pins == 2'h2 && !logic_uv && mode != ctmc_pkg::MODE_SLEEP
    |=> in_gts && hold_cnt == 16'h0000)
    else $error("go-to-sleep not entered");
  gts_start_a: assert property (
    s_gts_enter |-> hold_cnt == 16'h0000 && !supply_switch_oe_n)
    else $error("go-to-sleep started with a stale timer");
  gts_bound_a: assert property (
    in_gts |-> gts_age <= HOLD_LAST)
    else $error("go-to-sleep outlasted the hold window");
  hold_limit_a: assert property (
    in_gts && hold_done && !pin_event && vs_ok && !logic_uv
    |=> mode == ctmc_pkg::MODE_SLEEP ##1 hold_cnt == 16'h0000)
    else $error("sleep not entered at window end");
  sleep_path_a: assert property (
    mode == ctmc_pkg::MODE_SLEEP && $past(mode) != ctmc_pkg::MODE_SLEEP
    |-> $past(in_gts) || $past(logic_uv))
    else $error("sleep entered without go-to-sleep");
  vs_loss_a: assert property (
    !vs_ok |=> mode == ctmc_pkg::MODE_STANDBY && !wake_flag)
    else $error("battery loss did not force stand-by");
  sleep_wake_a: assert property (
    mode == ctmc_pkg::MODE_SLEEP && any_wake && vs_ok && !logic_uv
    |=> mode == ctmc_pkg::MODE_STANDBY && wake_flag)
    else $error("wake from sleep lost");
  switch_float_a: assert property (
    mode == ctmc_pkg::MODE_SLEEP |-> supply_switch_oe_n)
    else $error("supply switch driven in sleep");
  tx_block_a: assert property (
    mode != ctmc_pkg::MODE_NORMAL |-> !bus_drive_dominant)
    else $error("transmitter active outside normal");
  stuck_bus_a: assert property (
    bus_wake |-> rec_seen && dom_run == BUS_LAST)
    else $error("bus wake without a filtered dominant edge");
  diag_off_a: assert property (
    mode == ctmc_pkg::MODE_GOTOSLEEP |-> error_flag_n)
    else $error("diagnostics shown in go-to-sleep");

endmodule : ctmc_top

/* verification/ctmc_mcu_model.sv */
// Behavioural microcontroller that drives the two mode-select pins.
// Assumes the bench calls its tasks from one process, one call at a time.
module ctmc_mcu_model (
  input wire logic core_clk,
  output logic normal_select,
  output logic standby_n_select
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // Pin driving
  // Both pins rest low at power-up, as their pull-downs would leave them.
  initial begin
    normal_select = 1'b0;
    standby_n_select = 1'b0;
  end

  task automatic put(input logic [1:0] pins);
    @(posedge core_clk);
    normal_select <= pins[1];
    standby_n_select <= pins[0];
  endtask : put

  // The standby pin falls first, the normal pin gap plus one cycles later; a short
  // gap asks for Stand-By, a gap beyond the hold window for Sleep.
  task automatic stop(input int gap);
    put({normal_select, 1'b0});
    repeat (gap) @(posedge core_clk);
    put(2'b00);
  endtask : stop
endmodule : ctmc_mcu_model

/* verification/tb_top.sv */
// Self-checking bench for the transceiver mode controller.
// Assumes the design and the microcontroller model share one 100 MHz clock.
`include "ctmc_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} ctmc_exp_s;
  logic core_clk, rst_b, transmit_input, bus_dominant, local_wake_in;
  logic vs_ok, vcc_ok, vio_ok, failure_detected, psel, penable, pwrite;
  logic [`CTMC_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, normal_select, standby_n_select, bus_drive_dominant;
  logic receive_output, error_flag_n, supply_switch_out, supply_switch_oe_n;
  ctmc_exp_s exp_q[$];
  ctmc_exp_s e;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 60117;
  int n;
  logic [1:0] r;

  ctmc_mcu_model i_mcu (.core_clk(core_clk), .normal_select(normal_select),
    .standby_n_select(standby_n_select));
  ctmc_top #(.SLEEP_HOLD_CYC(HOLD)) i_dut (.core_clk(core_clk),
    .rst_b(rst_b), .normal_select(normal_select),
    .standby_n_select(standby_n_select), .transmit_input(transmit_input),
    .bus_dominant(bus_dominant), .local_wake_in(local_wake_in),
    .vs_ok(vs_ok), .vcc_ok(vcc_ok), .vio_ok(vio_ok),
    .failure_detected(failure_detected),
    .supply_switch_in(!supply_switch_oe_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .bus_drive_dominant(bus_drive_dominant), .receive_output(receive_output),
    .error_flag_n(error_flag_n), .supply_switch_out(supply_switch_out),
    .supply_switch_oe_n(supply_switch_oe_n));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Checking and reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("Checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic tend(input string s);
    $display("Test %s finished", s);
  endtask : tend

  // Read data is taken at the completing edge, the same edge the driver sees.
  always @(posedge core_clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      chk(prdata & e.m, e.d);
      chk({31'h0, pslverr}, {31'h0, e.e});
    end
  end

  // ==========================================================================
  // APB master
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      final_report;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m, input logic err);
    exp_q.push_back('{d, m, err});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic md(input ctmc_pkg::ctmc_mode_e m);
    rd(`CTMC_STATUS_ADDR, {29'h0, m}, 32'h0000_0007, 1'b0);
  endtask : md

  // ==========================================================================
  // Main sequence
  initial begin
    rst_b = 1'b0;
    {psel, penable, pwrite, transmit_input, bus_dominant} = 5'h08;
    {local_wake_in, vs_ok, vcc_ok, vio_ok, failure_detected} = 5'h0e;
    paddr = '0;
    pwdata = 32'h0;
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(`CTMC_STATUS_ADDR, 32'h0000_0052, 32'h0000_005f, 1'b0);
    #1 chk({31'h0, error_flag_n}, 32'h0);
    chk({31'h0, receive_output}, 32'h1);
    chk({31'h0, supply_switch_oe_n}, 32'h0);
    chk({31'h0, supply_switch_out}, 32'h1);
    tend("power_up");
    i_mcu.put(2'b11);
    md(ctmc_pkg::MODE_NORMAL);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      r = 2'($random(seed));
      transmit_input <= r[0];
      bus_dominant <= r[1];
      failure_detected <= r[0] ^ r[1];
      local_wake_in <= r[1];
      @(posedge core_clk);
      #1 chk({31'h0, bus_drive_dominant}, {31'h0, !r[0]});
      chk({31'h0, receive_output}, {31'h0, !r[1]});
      chk({31'h0, error_flag_n}, {31'h0, !(r[0] ^ r[1])});
    end
    @(posedge core_clk);
    {transmit_input, bus_dominant, failure_detected} <= 3'b010;
    local_wake_in <= 1'b0;
    i_mcu.put(2'b01);
    rd(`CTMC_STATUS_ADDR, 32'h1, 32'hf, 1'b0);
    #1 chk({31'h0, bus_drive_dominant}, 32'h0);
    chk({31'h0, receive_output}, 32'h0);
    i_mcu.put(2'b00);
    md(ctmc_pkg::MODE_STANDBY);
    bus_dominant <= 1'b0;
    tend("pin_modes");
    i_mcu.put(2'b10);
    md(ctmc_pkg::MODE_GOTOSLEEP);
    i_mcu.put(2'b00);
    md(ctmc_pkg::MODE_STANDBY);
    i_mcu.put(2'b11);
    i_mcu.stop(3);
    md(ctmc_pkg::MODE_STANDBY);
    #1 chk({31'h0, supply_switch_oe_n}, 32'h0);
    i_mcu.put(2'b11);
    i_mcu.put(2'b10);
    @(posedge core_clk);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (supply_switch_oe_n !== 1'b1 && n < 3 * HOLD);
    chk(32'(n), 32'(HOLD));
    i_mcu.put(2'b00);
    md(ctmc_pkg::MODE_SLEEP);
    tend("go_to_sleep");
    @(posedge core_clk);
    bus_dominant <= 1'b1;
    repeat (120) @(posedge core_clk);
    rd(`CTMC_STATUS_ADDR, 32'ha, 32'hf, 1'b0);
    #1 chk({31'h0, error_flag_n}, 32'h0);
    chk({31'h0, receive_output}, 32'h0);
    @(posedge core_clk);
    bus_dominant <= 1'b0;
    apb(1'b1, `CTMC_CTRL_ADDR, 32'($random(seed)) | 32'h0000_0003);
    rd(`CTMC_STATUS_ADDR, 32'h0000_0002, 32'h0000_001f, 1'b0);
    i_mcu.put(2'b11);
    i_mcu.stop(HOLD + 4);
    @(posedge core_clk);
    local_wake_in <= 1'b1;
    repeat (1100) @(posedge core_clk);
    rd(`CTMC_STATUS_ADDR, 32'h2a, 32'h2f, 1'b0);
    tend("wake");
    i_mcu.put(2'b11);
    md(ctmc_pkg::MODE_NORMAL);
    @(posedge core_clk);
    vs_ok <= 1'b0;
    rd(`CTMC_STATUS_ADDR, 32'h0000_0012, 32'h0000_001f, 1'b0);
    i_mcu.put(2'b01);
    @(posedge core_clk);
    vs_ok <= 1'b1;
    md(ctmc_pkg::MODE_STANDBY);
    i_mcu.put(2'b11);
    md(ctmc_pkg::MODE_NORMAL);
    @(posedge core_clk);
    r = 2'($random(seed));
    {vcc_ok, vio_ok} <= (r == 2'b11) ? 2'b00 : r;
    md(ctmc_pkg::MODE_SLEEP);
    #1 chk({31'h0, supply_switch_oe_n}, 32'h1);
    @(posedge core_clk);
    {vcc_ok, vio_ok} <= 2'b11;
    i_mcu.put(2'b01);
    md(ctmc_pkg::MODE_RXONLY);
    tend("supplies");
    rd(`CTMC_ID_ADDR, `CTMC_ID_VALUE, 32'hffff_ffff, 1'b0);
    rd(12'h00c, 32'h0, 32'hffff_ffff, 1'b1);
    apb(1'b1, `CTMC_STATUS_ADDR, 32'($random(seed)));
    md(ctmc_pkg::MODE_RXONLY);
    tend("registers");
    final_report;
  end

  // A hung wait anywhere ends the run through the same report.
  initial begin
    #200000;
    bad_count++;
    final_report;
  end
endmodule : tb_top
